// File: sfrm_consts.svh
// constants of the supply fault response manager
// Overview of operation
// - bit 14 tags channel local or group
// - group channel fault acts on all group channels
// - only group channels obey external trip pin
// - no enable while overvoltage or overtemperature present
// - group enable needs clean group and idle pin
// - qualify field filters excursions: 0,2,3,4 ms
// - temperature and sequencing faults skip the filter
// - two-bit action field per fault type
// - faulting channel action applies to whole group
// - enabled temperature sensor faults are ORed
// - group takes worst overtemperature action, locals own
// - record faults when enabled, except action 00
// - one voltage record until clear or disable
// - one record per sensor; sequencing always recorded
// - action 11: status, record, keep running
// - action 10: group off, wait, restart
// - retry holds trip pin until clean and waited
// - action 01: latch group off, assert pin
// - action 00: status bit only
// - alert on each newly set status bit
// - restart wait starts after last group channel off
// - zero restart wait skips the wait and restarts once the group is clean
`ifndef SFRM_CONSTS_SVH
`define SFRM_CONSTS_SVH
`define SFRM_CFG_RESET 16'h0000
`define SFRM_REC_EN_BIT 15
`define SFRM_GROUP_BIT 14
`define SFRM_QUAL_HI 13
`define SFRM_QUAL_LO 12
`define SFRM_OT_HI 7
`define SFRM_OT_LO 6
`define SFRM_TON_HI 5
`define SFRM_TON_LO 4
`define SFRM_UV_HI 3
`define SFRM_UV_LO 2
`define SFRM_OV_HI 1
`define SFRM_OV_LO 0
`define SFRM_QUAL_MS_01 3'h2
`define SFRM_QUAL_MS_10 3'h3
`define SFRM_QUAL_MS_11 3'h4
`define SFRM_CLK_HZ 20000000
`define SFRM_MS_PER_S 1000
`endif

// File: sfrm_pkg.sv
// types of the supply fault response manager
package sfrm_pkg;
   typedef enum logic [1:0] {
      ACT_IGNORE = 2'h0,
      ACT_LATCH = 2'h1,
      ACT_RETRY = 2'h2,
      ACT_REPORT = 2'h3
   } sfrm_act_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SHUT = 5'h02,
      ST_WAIT = 5'h04,
      ST_HOLD = 5'h08,
      ST_LATCH = 5'h10
   } sfrm_state_t;
endpackage : sfrm_pkg

// File: sfrm_qual.sv
// excursion persistence filter for one limit comparator
`timescale 1ns/1ps
`include "sfrm_consts.svh"
module sfrm_qual (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ms_tick,
   input wire logic raw,
   input wire logic [1:0] sel,
   output logic qual
);
   logic [2:0] cnt;
   logic [2:0] limit;

   always_comb begin
      unique case (sel)
         2'h0: limit = 3'h0;
         2'h1: limit = `SFRM_QUAL_MS_01;
         2'h2: limit = `SFRM_QUAL_MS_10;
         2'h3: limit = `SFRM_QUAL_MS_11;
      endcase
   end

   // ms granularity: persistence may run up to one tick short
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 3'h0;
         qual <= 1'b0;
      end else if (!raw) begin
         cnt <= 3'h0;
         qual <= 1'b0;
      end else begin
         if (ms_tick && cnt < limit) begin
            cnt <= cnt + 3'h1;
         end
         qual <= (cnt >= limit);
      end
   end
endmodule : sfrm_qual

// File: sfrm_timer.sv
// millisecond down-counter with a one-cycle done pulse
`timescale 1ns/1ps
module sfrm_timer #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ms_tick,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic done
);
   logic [W-1:0] cnt;
   logic busy;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt <= load_val;
            busy <= 1'b1;
         end else if (busy && ms_tick) begin
            if (cnt <= W'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt <= cnt - W'(1);
            end
         end
      end
   end
endmodule : sfrm_timer

// File: sfrm_fault_manager.sv
// fault qualification, response and enable control for all supply channels
`timescale 1ns/1ps
`include "sfrm_consts.svh"
module sfrm_fault_manager import sfrm_pkg::*; #(
   parameter int NCH = 16,
   parameter int NTS = 5,
   parameter int MS_CYCLES = `SFRM_CLK_HZ / `SFRM_MS_PER_S
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic cfg_wr,
   input wire logic [3:0] cfg_chan,
   input wire logic [15:0] cfg_wdata,
   input wire logic [3:0] cfg_rd_chan,
   output logic [15:0] cfg_rdata,
   input wire logic [NCH-1:0] seq_on_req,
   input wire logic [NCH-1:0] ov_raw,
   input wire logic [NCH-1:0] uv_raw,
   input wire logic [NCH-1:0] ton_fault,
   input wire logic [NTS-1:0] temp_fault_pin,
   input wire logic [NTS-1:0] temp_sensor_en,
   input wire logic clear_faults,
   input wire logic off_all_now,
   input wire logic [15:0] power_down_spacing,
   input wire logic [15:0] restart_wait,
   input wire logic group_pin_en,
   input wire logic alert_en,
   input wire logic group_trip_in,
   output logic group_trip_out,
   output logic group_trip_oe,
   output logic [NCH-1:0] supply_enable_out,
   output logic [NCH-1:0] ov_status,
   output logic [NCH-1:0] uv_status,
   output logic [NCH-1:0] ton_status,
   output logic ot_status,
   output logic alert,
   output logic [NCH-1:0] record_ov,
   output logic [NCH-1:0] record_uv,
   output logic [NCH-1:0] record_ton,
   output logic [NTS-1:0] record_ot
);
   localparam int MSW = $clog2(MS_CYCLES);

   // --------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------
   logic [15:0] cfg [NCH];
   logic [MSW-1:0] ms_cnt;
   logic ms_tick;
   logic trip_meta, trip_sync;
   logic [NTS-1:0] ts_meta, ts_sync, ts_prev;
   logic [NTS-1:0] ts_now, ts_evt;
   logic ot_now, ot_prev, ot_evt;
   logic pin_active;
   logic [NCH-1:0] ov_q, uv_q, ov_prev, uv_prev, ov_evt, uv_evt;
   logic [NCH-1:0] is_grp, rec_en, respond, own_latch, own_retry;
   logic [NCH-1:0] ov_blk, uv_blk;
   logic [NTS-1:0] ot_blk;
   logic [NCH-1:0] local_latched, local_hold, grp_kill;
   logic [NCH-1:0] grp_on, next_en, forced_off, start_ok;
   logic [1:0] ov_code [NCH];
   logic [1:0] uv_code [NCH];
   logic [1:0] ton_code [NCH];
   logic [1:0] ot_code [NCH];
   logic [1:0] grp_ot_act;
   logic ot_rec_any, grp_fault_any, grp_latch_req, grp_retry_req;
   logic latch_mode, new_status;
   sfrm_state_t st;
   logic sp_load, sp_done, rw_load, rw_done, lr_done;
   logic [15:0] sp_val;

   function automatic logic [1:0] sev(input logic [1:0] a);
      unique case (a)
         ACT_LATCH: sev = 2'h3;
         ACT_RETRY: sev = 2'h2;
         ACT_REPORT: sev = 2'h1;
         ACT_IGNORE: sev = 2'h0;
      endcase
   endfunction : sev

   // --------------------------------------------------------------
   // configuration store and read-back
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NCH; i++) begin
            cfg[i] <= `SFRM_CFG_RESET;
         end
      end else if (cfg_wr) begin
         cfg[cfg_chan] <= cfg_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_rdata <= 16'h0000;
      end else begin
         cfg_rdata <= cfg[cfg_rd_chan] & 16'hF0FF;
      end
   end

   // --------------------------------------------------------------
   // millisecond tick and pin synchronisers
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ms_cnt <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == MSW'(MS_CYCLES - 1));
         ms_cnt <= (ms_cnt == MSW'(MS_CYCLES - 1)) ? '0 : ms_cnt + MSW'(1);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trip_meta <= 1'b0;
         trip_sync <= 1'b0;
         ts_meta <= '0;
         ts_sync <= '0;
         ts_prev <= '0;
         ot_prev <= 1'b0;
         ov_prev <= '0;
         uv_prev <= '0;
      end else begin
         trip_meta <= group_trip_in;
         trip_sync <= trip_meta;
         ts_meta <= temp_fault_pin;
         ts_sync <= ts_meta;
         ts_prev <= ts_now;
         ot_prev <= ot_now;
         ov_prev <= ov_q;
         uv_prev <= uv_q;
      end
   end

   // the pin is only ours to obey while the group drives nothing itself
   assign pin_active = trip_sync & group_pin_en & (st == ST_IDLE);
   assign ts_now = ts_sync & temp_sensor_en;
   assign ts_evt = ts_now & ~ts_prev;
   assign ot_now = |ts_now;
   assign ot_evt = ot_now & ~ot_prev;
   assign ov_evt = ov_q & ~ov_prev;
   assign uv_evt = uv_q & ~uv_prev;

   // --------------------------------------------------------------
   // per channel field decode and qualification
   // --------------------------------------------------------------
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [1:0] qsel;
      assign qsel = cfg[c][`SFRM_QUAL_HI:`SFRM_QUAL_LO];
      assign is_grp[c] = cfg[c][`SFRM_GROUP_BIT];
      assign rec_en[c] = cfg[c][`SFRM_REC_EN_BIT];
      assign ov_code[c] = cfg[c][`SFRM_OV_HI:`SFRM_OV_LO];
      assign uv_code[c] = cfg[c][`SFRM_UV_HI:`SFRM_UV_LO];
      assign ton_code[c] = cfg[c][`SFRM_TON_HI:`SFRM_TON_LO];
      assign ot_code[c] = cfg[c][`SFRM_OT_HI:`SFRM_OT_LO];
      sfrm_qual u_ov (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .ms_tick(ms_tick),
         .raw(ov_raw[c]),
         .sel(qsel),
         .qual(ov_q[c])
      );
      sfrm_qual u_uv (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .ms_tick(ms_tick),
         .raw(uv_raw[c]),
         .sel(qsel),
         .qual(uv_q[c])
      );
   end

   // --------------------------------------------------------------
   // action selection
   // --------------------------------------------------------------
   always_comb begin
      logic [1:0] ota;
      ota = 2'h0;
      grp_ot_act = ACT_IGNORE;
      ot_rec_any = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         if (is_grp[i] && sev(ot_code[i]) > sev(grp_ot_act)) begin
            grp_ot_act = ot_code[i];
         end
         ot_rec_any = ot_rec_any | (rec_en[i] & (ot_code[i] != ACT_IGNORE));
      end
      for (int i = 0; i < NCH; i++) begin
         ota = is_grp[i] ? grp_ot_act : ot_code[i];
         respond[i] = ov_evt[i] | uv_evt[i] | ton_fault[i] | ot_evt;
         own_latch[i] = (ov_evt[i] && ov_code[i] == ACT_LATCH)
            || (uv_evt[i] && uv_code[i] == ACT_LATCH)
            || (ton_fault[i] && ton_code[i] == ACT_LATCH)
            || (ot_evt && ota == ACT_LATCH);
         own_retry[i] = (ov_evt[i] && ov_code[i] == ACT_RETRY)
            || (uv_evt[i] && uv_code[i] == ACT_RETRY)
            || (ton_fault[i] && ton_code[i] == ACT_RETRY)
            || (ot_evt && ota == ACT_RETRY);
      end
   end

   // one group member's action becomes the action of every member
   assign grp_latch_req = |(own_latch & is_grp);
   assign grp_retry_req = |(own_retry & is_grp);
   assign grp_fault_any = (|(is_grp & (ov_q | uv_q))) | ot_now;
   assign grp_on = is_grp & supply_enable_out & ~grp_kill;

   // --------------------------------------------------------------
   // group shutdown, wait and restart sequence
   // --------------------------------------------------------------
   always_comb begin
      sp_load = 1'b0;
      rw_load = 1'b0;
      if (st == ST_IDLE && (grp_latch_req || grp_retry_req)) begin
         sp_load = 1'b1;
      end else if (st == ST_SHUT && sp_done && grp_on != '0) begin
         sp_load = 1'b1;
      end else if (st == ST_SHUT && grp_on == '0 && !latch_mode && restart_wait != 16'h0000) begin
         rw_load = 1'b1;
      end
   end
   assign sp_val = power_down_spacing;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= ST_IDLE;
         latch_mode <= 1'b0;
         grp_kill <= '0;
      end else begin
         unique case (st)
            ST_IDLE: begin
               if (grp_latch_req || grp_retry_req) begin
                  st <= ST_SHUT;
                  latch_mode <= grp_latch_req;
                  // either all at once or the lowest channel first
                  grp_kill <= off_all_now ? grp_on : (grp_on & (~grp_on + NCH'(1)));
               end
            end
            ST_SHUT: begin
               latch_mode <= latch_mode | grp_latch_req;
               if (grp_on == '0) begin
                  if (latch_mode) begin
                     st <= ST_LATCH;
                  end else if (restart_wait == 16'h0000) begin
                     st <= ST_HOLD;
                  end else begin
                     st <= ST_WAIT;
                  end
               end else if (sp_done) begin
                  grp_kill <= grp_kill | (grp_on & (~grp_on + NCH'(1)));
               end
            end
            ST_WAIT: begin
               if (grp_latch_req) begin
                  st <= ST_LATCH;
               end else if (rw_done) begin
                  st <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (grp_latch_req) begin
                  st <= ST_LATCH;
               end else if (!grp_fault_any) begin
                  st <= ST_IDLE;
                  grp_kill <= '0;
               end
            end
            ST_LATCH: begin
               // a fault in the clearing cycle keeps the group latched
               if (clear_faults && !(grp_latch_req || grp_retry_req)) begin
                  st <= ST_IDLE;
                  grp_kill <= '0;
               end
            end
         endcase
      end
   end

   sfrm_timer u_spacing (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick),
      .load(sp_load),
      .load_val(sp_val),
      .done(sp_done)
   );

   sfrm_timer u_restart (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick),
      .load(rw_load),
      .load_val(restart_wait),
      .done(rw_done)
   );

   // local retries share one wait; a later retry extends the earlier ones
   sfrm_timer u_local (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick),
      .load(|(own_retry & ~is_grp)),
      .load_val(restart_wait),
      .done(lr_done)
   );

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         local_latched <= '0;
         local_hold <= '0;
      end else begin
         local_latched <= (clear_faults ? '0 : local_latched) | (own_latch & ~is_grp);
         local_hold <= (lr_done ? '0 : local_hold) | (own_retry & ~is_grp);
      end
   end

   // --------------------------------------------------------------
   // supply enables and trip pin
   // --------------------------------------------------------------
   assign forced_off = local_latched | local_hold
      | (is_grp & (grp_kill | {NCH{pin_active}}));
   assign start_ok = ~ov_q & {NCH{~ot_now}}
      & (~is_grp | {NCH{~grp_fault_any & ~pin_active & (st == ST_IDLE)}});
   // a running supply stays on through report-only faults
   assign next_en = seq_on_req & ~forced_off & (supply_enable_out | start_ok);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         supply_enable_out <= '0;
         group_trip_out <= 1'b0;
         group_trip_oe <= 1'b0;
      end else begin
         supply_enable_out <= next_en;
         group_trip_out <= 1'b0;
         group_trip_oe <= (st != ST_IDLE);
      end
   end

   // --------------------------------------------------------------
   // status bits and alert
   // --------------------------------------------------------------
   assign new_status = |(ov_evt & ~ov_status) | |(uv_evt & ~uv_status)
      | |(ton_fault & ~ton_status) | (ot_evt & ~ot_status);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ov_status <= '0;
         uv_status <= '0;
         ton_status <= '0;
         ot_status <= 1'b0;
         alert <= 1'b0;
      end else begin
         ov_status <= (clear_faults ? '0 : ov_status) | ov_evt;
         uv_status <= (clear_faults ? '0 : uv_status) | uv_evt;
         ton_status <= (clear_faults ? '0 : ton_status) | ton_fault;
         ot_status <= (ot_status & ~clear_faults) | (ot_evt & |respond);
         alert <= alert_en & ((alert & ~clear_faults) | new_status);
      end
   end

   // --------------------------------------------------------------
   // record requests
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         record_ov <= '0;
         record_uv <= '0;
         record_ton <= '0;
         record_ot <= '0;
         ov_blk <= '0;
         uv_blk <= '0;
         ot_blk <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            record_ov[i] <= ov_evt[i] & rec_en[i] & (ov_code[i] != ACT_IGNORE) & ~ov_blk[i];
            record_uv[i] <= uv_evt[i] & rec_en[i] & (uv_code[i] != ACT_IGNORE) & ~uv_blk[i];
            record_ton[i] <= ton_fault[i] & rec_en[i] & (ton_code[i] != ACT_IGNORE);
         end
         ov_blk <= ((clear_faults ? '0 : ov_blk) & supply_enable_out)
            | (ov_evt & rec_en);
         uv_blk <= ((clear_faults ? '0 : uv_blk) & supply_enable_out) | (uv_evt & rec_en);
         record_ot <= ts_evt & ~ot_blk & {NTS{ot_rec_any}};
         ot_blk <= (clear_faults ? '0 : ot_blk) | (ts_evt & {NTS{ot_rec_any}});
      end
   end
endmodule : sfrm_fault_manager

// File: sfrm_monitor.sv
// port checker for the supply fault manager
`timescale 1ns/1ps
module sfrm_monitor #(
   parameter int NCH = 16,
   parameter int NTS = 5
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [NCH-1:0] seq_on_req,
   input wire logic [NCH-1:0] ton_fault,
   input wire logic clear_faults,
   input wire logic alert_en,
   input wire logic group_trip_out,
   input wire logic group_trip_oe,
   input wire logic [NCH-1:0] supply_enable_out,
   input wire logic [NCH-1:0] ov_status,
   input wire logic [NCH-1:0] uv_status,
   input wire logic [NCH-1:0] ton_status,
   input wire logic ot_status,
   input wire logic alert,
   input wire logic [NCH-1:0] record_ov,
   input wire logic [NCH-1:0] record_uv
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_pin_low; group_trip_out == 1'b0; endproperty
   a_pin_low: assert property (p_pin_low) else $error("trip pin driven high");
   property p_en_req; (supply_enable_out & ~$past(seq_on_req)) == '0; endproperty
   a_en_req: assert property (p_en_req) else $error("enable without request");
   property p_alert_off; (!alert_en) [*2] |-> !alert; endproperty
   a_alert_off: assert property (p_alert_off) else $error("alert while disabled");
   property p_alert_why; $rose(alert) |-> ((ov_status | uv_status | ton_status) != '0) || ot_status;
   endproperty
   a_alert_why: assert property (p_alert_why) else $error("alert without status");
   property p_sticky;
      !clear_faults |=> (($past(ov_status) & ~ov_status) | ($past(uv_status) & ~uv_status)) == '0;
   endproperty
   a_sticky: assert property (p_sticky) else $error("status fell without clear");
   property p_rec_pulse;
      |(record_ov | record_uv) |=>
         ((record_ov & $past(record_ov)) | (record_uv & $past(record_uv))) == '0;
   endproperty
   a_rec_pulse: assert property (p_rec_pulse) else $error("record not a pulse");
   property p_rec_stat; ((record_ov & ~ov_status) | (record_uv & ~uv_status)) == '0; endproperty
   a_rec_stat: assert property (p_rec_stat) else $error("record without status");
   property p_ton_stat;
      |ton_fault |=> (ton_status & $past(ton_fault)) == $past(ton_fault);
   endproperty
   a_ton_stat: assert property (p_ton_stat) else $error("timeout status late");
   c_trip: cover property ($rose(group_trip_oe));
   c_alert: cover property ($rose(alert));
   c_rec: cover property (|record_uv);
endmodule : sfrm_monitor

bind sfrm_fault_manager sfrm_monitor #(.NCH(NCH), .NTS(NTS)) i_sfrm_monitor (.core_clk,
   .sys_rst, .seq_on_req, .ton_fault, .clear_faults, .alert_en, .group_trip_out, .group_trip_oe,
   .supply_enable_out, .ov_status, .uv_status, .ton_status, .ot_status, .alert, .record_ov,
   .record_uv);

// File: sfrm_peer.sv
// peer sequencer sharing the open-drain trip line
`timescale 1ns/1ps
module sfrm_peer (
   input wire logic peer_fault,
   input wire logic group_trip_oe,
   output logic group_trip_in
);
   // wired pull-down: asserted when any party pulls, never left floating
   assign group_trip_in = group_trip_oe | peer_fault;
endmodule : sfrm_peer

// File: tb.sv
// self-checking bench for the supply fault manager
`timescale 1ns/1ps
module tb;
   localparam int MS = 20;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_wr = 1'b0;
   logic [3:0] cfg_chan = 4'h0;
   logic [15:0] cfg_wdata = 16'h0000;
   logic [3:0] cfg_rd_chan = 4'h0;
   logic [15:0] seq_on_req = 16'h0000;
   logic [15:0] ov_raw = 16'h0000;
   logic [15:0] uv_raw = 16'h0000;
   logic [15:0] ton_fault = 16'h0000;
   logic [4:0] temp_fault_pin = 5'h00;
   logic [4:0] temp_sensor_en = 5'h00;
   logic clear_faults = 1'b0;
   logic off_all_now = 1'b1;
   logic [15:0] power_down_spacing = 16'h0002;
   logic [15:0] restart_wait = 16'h0002;
   logic alert_en = 1'b0;
   logic peer_fault = 1'b0;
   logic group_trip_in, group_trip_out, group_trip_oe, ot_status, alert;
   logic [15:0] cfg_rdata, supply_enable_out, ov_status, uv_status, ton_status;
   logic [15:0] record_ov, record_uv, record_ton;
   logic [4:0] record_ot;
   int n_errors = 0;
   int tests_run = 0;
   int n_rec = 0;
   int n_rov = 0;
   int n_rot = 0;
   logic group_pin_en = 1'b1;

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) if (record_uv[2]) n_rec <= n_rec + 1;
   always @(posedge core_clk) if (record_ov[2]) n_rov <= n_rov + 1;
   always @(posedge core_clk) if (record_ot[1]) n_rot <= n_rot + 1;

   sfrm_fault_manager #(.NCH(16), .NTS(5), .MS_CYCLES(MS)) i_sfrm_fault_manager (.core_clk,
      .sys_rst, .cfg_wr, .cfg_chan, .cfg_wdata, .cfg_rd_chan, .cfg_rdata, .seq_on_req, .ov_raw,
      .uv_raw, .ton_fault, .temp_fault_pin, .temp_sensor_en, .clear_faults, .off_all_now,
      .power_down_spacing, .restart_wait, .group_pin_en, .alert_en, .group_trip_in,
      .group_trip_out, .group_trip_oe, .supply_enable_out, .ov_status, .uv_status, .ton_status,
      .ot_status, .alert, .record_ov, .record_uv, .record_ton, .record_ot);
   sfrm_peer i_sfrm_peer (.peer_fault, .group_trip_oe, .group_trip_in);

   // ---------
   // helpers
   // ---------
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] ch, input logic [15:0] v);
      cfg_chan = ch;
      cfg_wdata = v;
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(1);
   endtask : wr
   task automatic clr();
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
      cyc(2);
   endtask : clr
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   // bounded wait on masked enables; running out ends the run
   task automatic wait_en(input logic [15:0] m, input logic [15:0] v, input int n);
      for (int i = 0; i < n && (supply_enable_out & m) !== v; i++) cyc(1);
      tests_run++;
      if ((supply_enable_out & m) !== v) begin
         $display("MISMATCH enables expected %h seen %h", v, supply_enable_out & m);
         n_errors++;
         test_done();
      end
   endtask : wait_en

   // ---------
   // scenarios
   // ---------
   task automatic t_setup();
      cyc(1);
      chk("reset enables", 16'h0000, supply_enable_out);
      chk("reset cfg", 16'h0000, cfg_rdata);
      wr(4'h3, 16'hFFFF);
      cfg_rd_chan = 4'h3;
      cyc(2);
      chk("cfg ch3", 16'hF0FF, cfg_rdata);
      // group members take the lowest channels, 0 and 1, though any channel may be a member
      wr(4'h0, 16'hC004);
      wr(4'h1, 16'hC004);
      wr(4'h2, 16'h800C);
      wr(4'h3, 16'hB0FF);
      alert_en = 1'b1;
      seq_on_req = 16'hFFFF;
      wait_en(16'hFFFF, 16'hFFFF, 10);
      $display("setup done");
   endtask : t_setup
   task automatic t_local();
      ov_raw[2] = 1'b1;
      cyc(4);
      chk("ov status", 16'h0004, ov_status);
      chk("alert", 16'h0001, alert);
      chk("enables", 16'hFFFF, supply_enable_out);
      seq_on_req[2] = 1'b0;
      cyc(3);
      seq_on_req[2] = 1'b1;
      cyc(4);
      chk("held off", 16'hFFFB, supply_enable_out);
      chk("ov records", 16'h0000, n_rov[15:0]);
      ov_raw[2] = 1'b0;
      wait_en(16'h0004, 16'h0004, 10);
      ton_fault[2] = 1'b1;
      cyc(1);
      ton_fault[2] = 1'b0;
      cyc(2);
      chk("ton status", 16'h0004, ton_status);
      $display("local done");
   endtask : t_local
   task automatic t_record();
      repeat (2) begin
         uv_raw[2] = 1'b1;
         cyc(3);
         uv_raw[2] = 1'b0;
         cyc(3);
      end
      chk("uv records", 16'h0001, n_rec[15:0]);
      chk("running", 16'h0004, supply_enable_out & 16'h0004);
      clr();
      chk("alert cleared", 16'h0000, alert);
      uv_raw[2] = 1'b1;
      cyc(3);
      uv_raw[2] = 1'b0;
      cyc(2);
      chk("uv records", 16'h0002, n_rec[15:0]);
      chk("alert again", 16'h0001, alert);
      $display("record done");
   endtask : t_record
   task automatic t_latch();
      uv_raw[0] = 1'b1;
      cyc(5);
      chk("group off", 16'h0004, supply_enable_out & 16'h0007);
      chk("trip oe", 16'h0001, group_trip_oe);
      chk("uv status", 16'h0001, uv_status & 16'h0003);
      uv_raw[0] = 1'b0;
      cyc(200);
      chk("latched", 16'h0000, supply_enable_out & 16'h0003);
      clr();
      wait_en(16'h0003, 16'h0003, 20);
      chk("trip oe", 16'h0000, group_trip_oe);
      $display("latch done");
   endtask : t_latch
   task automatic t_pin();
      group_pin_en = 1'b0;
      peer_fault = 1'b1;
      cyc(5);
      chk("pin disabled", 16'h000F, supply_enable_out & 16'h000F);
      group_pin_en = 1'b1;
      cyc(5);
      chk("pin off", 16'h000C, supply_enable_out & 16'h000F);
      peer_fault = 1'b0;
      wait_en(16'h0003, 16'h0003, 10);
      $display("pin done");
   endtask : t_pin
   task automatic t_retry();
      wr(4'h0, 16'hC008);
      off_all_now = 1'b0;
      uv_raw[0] = 1'b1;
      cyc(5);
      chk("first off", 16'h0002, supply_enable_out & 16'h0003);
      wait_en(16'h0003, 16'h0000, 50);
      cyc(200);
      chk("trip held", 16'h0001, group_trip_oe);
      chk("still off", 16'h0000, supply_enable_out & 16'h0003);
      uv_raw[0] = 1'b0;
      wait_en(16'h0003, 16'h0003, 20);
      chk("trip oe", 16'h0000, group_trip_oe);
      $display("retry done");
   endtask : t_retry
   task automatic t_filter();
      // 2 ms stays below channel 3's 4 ms qualify allowing tick jitter
      ov_raw[3] = 1'b1;
      cyc(2 * MS);
      ov_raw[3] = 1'b0;
      cyc(3);
      chk("short excursion", 16'h0000, ov_status & 16'h0008);
      ov_raw[3] = 1'b1;
      cyc(5 * MS);
      chk("long excursion", 16'h0008, ov_status & 16'h0008);
      chk("report only", 16'hFFFF, supply_enable_out);
      ov_raw[3] = 1'b0;
      $display("filter done");
   endtask : t_filter
   task automatic t_temp();
      temp_sensor_en = 5'h02;
      temp_fault_pin = 5'h01;
      cyc(6);
      chk("disabled sensor", 16'h0000, ot_status);
      temp_fault_pin = 5'h02;
      cyc(5);
      chk("ot status", 16'h0001, ot_status);
      chk("ot enables", 16'hFFFF, supply_enable_out);
      chk("ot records", 16'h0001, n_rot[15:0]);
      temp_fault_pin = 5'h00;
      $display("temp done");
   endtask : t_temp

   initial begin
      cyc(4);
      sys_rst = 1'b0;
      t_setup();
      t_local();
      t_record();
      t_latch();
      t_pin();
      t_retry();
      t_filter();
      t_temp();
      test_done();
   end
endmodule : tb
